// File: rtl/pmx_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants for the peripheral pin remap mux
// Assumes: pins are numbered port*16+bit, ports A..D as 0..3
// Notes:   route tables are packed, entry 0 in the rightmost slot
//////////////////////////////////////////////////////////////////////////////
package pmx_pkg;

  localparam int PIN_W     = 6;
  localparam int PIN_COUNT = 64;
  localparam int NSIG      = 25;

  // peripheral signal slots in the flat route vector
  localparam int SIG_SER0 = 0;
  localparam int SIG_SER1 = 2;
  localparam int SIG_SER2 = 7;
  localparam int SIG_TW0  = 12;
  localparam int SIG_SS0  = 14;
  localparam int SIG_SS2  = 20;
  localparam int SIG_TRIM = 24;

  // field positions in the first remap configuration word
  localparam int CFG1_W    = 7;
  localparam int F_SER0    = 0;
  localparam int F_SER1    = 1;
  localparam int F_SER2_LO = 2;
  localparam int F_TW0     = 4;
  localparam int F_SS0     = 5;
  localparam int F_SS2     = 6;
  // second remap configuration word: trim sync select
  localparam int CFG2_W    = 2;

  localparam logic [1:0] SER2_DFLT  = 2'h0;
  localparam logic [1:0] SER2_PART  = 2'h1;
  localparam logic [1:0] SER2_FULL  = 2'h3;
  localparam logic [1:0] TRIM_DFLT  = 2'h0;
  localparam logic [1:0] TRIM_ALT   = 2'h1;

  // package strap codes
  localparam logic [1:0] PKG_36  = 2'h0;
  localparam logic [1:0] PKG_48  = 2'h1;
  localparam logic [1:0] PKG_64  = 2'h2;
  localparam logic [1:0] PKG_100 = 2'h3;

  // crystal pins
  localparam int PIN_LOW_HIGH_PIN_A  = 'h2e;
  localparam int PIN_LOW_HIGH_PIN_B = 'h2f;
  localparam int PIN_HIGH_A      = 'h30;
  localparam int PIN_HIGH_B      = 'h31;

  localparam logic [63:0] RST_PINS = 64'h0;

  // route tables: tx,rx
  localparam logic [1:0][5:0] SER0_MAP0 = {6'h0a, 6'h09};
  localparam logic [1:0][5:0] SER0_MAP1 = {6'h17, 6'h16};
  // cts,rts,tx,rx,ck
  localparam logic [4:0][5:0] SER1_MAP0 =
    {6'h04, 6'h03, 6'h02, 6'h01, 6'h00};
  localparam logic [4:0][5:0] SER1_MAP1 =
    {6'h37, 6'h36, 6'h35, 6'h34, 6'h33};
  // tx,rx,ck,cts,rts
  localparam logic [4:0][5:0] SER2_MAP0 =
    {6'h1e, 6'h1d, 6'h1c, 6'h1b, 6'h1a};
  localparam logic [4:0][5:0] SER2_MAP1 =
    {6'h1e, 6'h1d, 6'h2c, 6'h2b, 6'h2a};
  localparam logic [4:0][5:0] SER2_MAP3 =
    {6'h3c, 6'h3b, 6'h3a, 6'h39, 6'h38};
  // clock,data
  localparam logic [1:0][5:0] TW0_MAP0 = {6'h17, 6'h16};
  localparam logic [1:0][5:0] TW0_MAP1 = {6'h19, 6'h18};
  // select,clock,miso,mosi,quad2,quad3
  localparam logic [5:0][5:0] SS0_MAP0 =
    {6'h03, 6'h02, 6'h07, 6'h06, 6'h05, 6'h04};
  localparam logic [5:0][5:0] SS0_MAP1 =
    {6'h17, 6'h16, 6'h15, 6'h14, 6'h13, 6'h0f};
  // select,clock,miso,mosi
  localparam logic [3:0][5:0] SS2_MAP0 =
    {6'h15, 6'h14, 6'h13, 6'h0f};
  localparam logic [3:0][5:0] SS2_MAP1 =
    {6'h2c, 6'h2b, 6'h2a, 6'h04};
  localparam logic [5:0] TRIM_MAP0 = 6'h08;
  localparam logic [5:0] TRIM_MAP1 = 6'h3f;

endpackage

// File: rtl/pmx_route.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: crossbar between peripheral signal slots and the pin space
// Assumes: each slot carries a pin number, drive value and drive enable
// Notes:   purely combinational; lowest slot wins a shared pin
//////////////////////////////////////////////////////////////////////////////
module pmx_route
  import pmx_pkg::*;
(
  input  wire logic [NSIG-1:0][PIN_W-1:0] sig_pin_in,
  input  wire logic [NSIG-1:0]            sig_drv_in,
  input  wire logic [NSIG-1:0]            sig_oe_in,
  input  wire logic [PIN_COUNT-1:0]       pin_val_in,
  output logic      [PIN_COUNT-1:0]       af_out,
  output logic      [PIN_COUNT-1:0]       af_oe_out,
  output logic      [NSIG-1:0]            sig_val_out
);

  // scan downward so the lowest slot is assigned last and wins;
  // a pin shared by two enabled peripherals is a software fault
  function automatic logic [1:0] pick(input int p);
    logic [1:0] r;
    r = 2'h0;
    for (int k = NSIG - 1; k >= 0; k--) begin
      if (sig_oe_in[k] && sig_pin_in[k] == PIN_W'(p)) begin
        r = {1'b1, sig_drv_in[k]};
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin side: output value and enable for every pin
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
    assign {af_oe_out[p], af_out[p]} = pick(p);
  end

  //////////////////////////////////////////////////////////////////////////
  // peripheral side: each slot reads its routed pin
  for (genvar k = 0; k < NSIG; k++) begin : g_sig
    assign sig_val_out[k] = pin_val_in[sig_pin_in[k]];
  end

endmodule

// File: rtl/pmx_pin_remap_mux.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: alternate-function pin routing and crystal pin fallback
// Assumes: pin, power and strap inputs are asynchronous; config and gpio
//          controls come from logic on CLK_IN
// Notes:   every output is registered; one cycle behind config and controls, three behind pin and power inputs
//
// Summary of operation
// - serial0 tx/rx on A9/A10 or B6/B7; serial1 on A0-A4 or D3-D7
// - serial2 code 00 B10-14, 01 C10-12 with B13/14, 11 D8-D12
// - two-wire0 clock/data on B6/B7 when clear, B8/B9 when set
// - syncser0 on A4,A5,A6,A7,A2,A3 or A15,B3,B4,B5,B6,B7
// - syncser2/audio on A15,B3,B4,B5 or A4,C10,C11,C12
// - trim sync input from A8 with code 00, D15 with code 01
// - trim select in second config word, all others in first
// - low crystal off, core powered and no battery backup: C14/C15 act as separate general-purpose pins
// - low crystal on: oscillator overrides any general-purpose use of C14/C15
// - core powered down or battery backup, low crystal off: C14/C15 forced analog
// - high crystal off: D0/D1 are general-purpose, on: oscillator pins
// - D0/D1 never feed event generation on 36/48/64-pin packages
//////////////////////////////////////////////////////////////////////////////
module pmx_pin_remap_mux
  import pmx_pkg::*;
(
  input  wire logic                 CLK_IN,
  input  wire logic                 RST_B_IN,
  input  wire logic [CFG1_W-1:0]    REMAP_CONFIG_REG_FIRST_IN,
  input  wire logic [CFG2_W-1:0]    REMAP_CONFIG_REG_SECOND_IN,
  input  wire logic                 LOW_SPEED_CRYSTAL_OSC_ON_IN,
  input  wire logic                 HIGH_SPEED_CRYSTAL_OSC_ON_IN,
  input  wire logic                 CORE_POWER_DOWN_IN,
  input  wire logic                 BACKUP_ON_BATTERY_IN,
  input  wire logic [1:0]           PACKAGE_STRAP_IN,
  input  wire logic [PIN_COUNT-1:0] GPIO_DRV_IN,
  input  wire logic [PIN_COUNT-1:0] GPIO_OE_IN,
  input  wire logic [PIN_COUNT-1:0] AF_MODE_IN,
  input  wire logic [PIN_COUNT-1:0] PIN_IN,
  input  wire logic [1:0]           SERIAL0_DRV_IN,
  input  wire logic [1:0]           SERIAL0_OE_IN,
  input  wire logic [4:0]           SERIAL1_DRV_IN,
  input  wire logic [4:0]           SERIAL1_OE_IN,
  input  wire logic [4:0]           SERIAL2_DRV_IN,
  input  wire logic [4:0]           SERIAL2_OE_IN,
  input  wire logic [1:0]           TWOWIRE0_DRV_IN,
  input  wire logic [1:0]           TWOWIRE0_OE_IN,
  input  wire logic [5:0]           SYNCSER0_DRV_IN,
  input  wire logic [5:0]           SYNCSER0_OE_IN,
  input  wire logic [3:0]           SYNCSER2_DRV_IN,
  input  wire logic [3:0]           SYNCSER2_OE_IN,
  output logic      [PIN_COUNT-1:0] PIN_OUT,
  output logic      [PIN_COUNT-1:0] PIN_OE_OUT,
  output logic      [PIN_COUNT-1:0] GPIO_VAL_OUT,
  output logic      [1:0]           LOW_OSC_ANALOG_OUT,
  output logic                      LOW_OSC_PINS_OWNED_OUT,
  output logic                      HIGH_OSC_PINS_OWNED_OUT,
  output logic                      EVENT_HIGH_PINS_OK_OUT,
  output logic      [PIN_COUNT-1:0] EVENT_SRC_OUT,
  output logic      [1:0]           SERIAL0_VAL_OUT,
  output logic      [4:0]           SERIAL1_VAL_OUT,
  output logic      [4:0]           SERIAL2_VAL_OUT,
  output logic      [1:0]           TWOWIRE0_VAL_OUT,
  output logic      [5:0]           SYNCSER0_VAL_OUT,
  output logic      [3:0]           SYNCSER2_VAL_OUT,
  output logic                      TRIM_SYNC_INPUT_OUT
);

  logic [PIN_COUNT-1:0]       pin_s1_q, pin_s2_q;
  logic [3:0]                 asy_s1_q, asy_s2_q;
  logic [1:0]                 pkg_q;
  logic [1:0]                 strap_wait_q;
  logic                       strap_done_q;
  logic [NSIG-1:0][PIN_W-1:0] sig_pin;
  logic [NSIG-1:0]            sig_drv, sig_oe, sig_val;
  logic [PIN_COUNT-1:0]       af_out, af_oe;
  logic [PIN_COUNT-1:0]       osc_mask, out_d, oe_d, gpio_d, event_d;
  logic [1:0]                 analog_d;
  logic                       low_on, high_on, low_lost, event_ok_d;
  logic                       serial0_sel, serial1_sel;
  logic                       twowire0_sel, syncser0_sel, syncser2_sel;
  logic [1:0]                 serial2_route_sel, trim_sync_route_sel;
  logic [4:0][PIN_W-1:0]      ser2_map;

  //////////////////////////////////////////////////////////////////////////
  // select fields, pulled from the two configuration words
  assign serial0_sel  = REMAP_CONFIG_REG_FIRST_IN[F_SER0];
  assign serial1_sel  = REMAP_CONFIG_REG_FIRST_IN[F_SER1];
  assign serial2_route_sel =
    REMAP_CONFIG_REG_FIRST_IN[F_SER2_LO +: 2];
  assign twowire0_sel = REMAP_CONFIG_REG_FIRST_IN[F_TW0];
  assign syncser0_sel = REMAP_CONFIG_REG_FIRST_IN[F_SS0];
  assign syncser2_sel = REMAP_CONFIG_REG_FIRST_IN[F_SS2];
  assign trim_sync_route_sel = REMAP_CONFIG_REG_SECOND_IN;

  //////////////////////////////////////////////////////////////////////////
  // serial2 table; the reserved code falls back to the plain map
  assign ser2_map =
    (serial2_route_sel == SER2_PART) ? SER2_MAP1 :
    (serial2_route_sel == SER2_FULL) ? SER2_MAP3 :
                                       SER2_MAP0;

  // pin number for every peripheral slot
  assign sig_pin[SIG_SER0 +: 2] =
    serial0_sel ? SER0_MAP1 : SER0_MAP0;
  assign sig_pin[SIG_SER1 +: 5] =
    serial1_sel ? SER1_MAP1 : SER1_MAP0;
  assign sig_pin[SIG_SER2 +: 5] = ser2_map;
  assign sig_pin[SIG_TW0 +: 2] =
    twowire0_sel ? TW0_MAP1 : TW0_MAP0;
  assign sig_pin[SIG_SS0 +: 6] =
    syncser0_sel ? SS0_MAP1 : SS0_MAP0;
  assign sig_pin[SIG_SS2 +: 4] =
    syncser2_sel ? SS2_MAP1 : SS2_MAP0;
  // codes other than 01 stay on the default pin
  assign sig_pin[SIG_TRIM] =
    (trim_sync_route_sel == TRIM_ALT) ? TRIM_MAP1 : TRIM_MAP0;

  // drive values and enables, same slot order; trim sync is input only
  assign sig_drv = {1'b0, SYNCSER2_DRV_IN, SYNCSER0_DRV_IN,
                    TWOWIRE0_DRV_IN, SERIAL2_DRV_IN, SERIAL1_DRV_IN,
                    SERIAL0_DRV_IN};
  assign sig_oe  = {1'b0, SYNCSER2_OE_IN, SYNCSER0_OE_IN,
                    TWOWIRE0_OE_IN, SERIAL2_OE_IN, SERIAL1_OE_IN,
                    SERIAL0_OE_IN};

  //////////////////////////////////////////////////////////////////////////
  // crossbar reads only the second synchroniser stage
  pmx_route u_route (
    .sig_pin_in  (sig_pin),
    .sig_drv_in  (sig_drv),
    .sig_oe_in   (sig_oe),
    .pin_val_in  (pin_s2_q),
    .af_out      (af_out),
    .af_oe_out   (af_oe),
    .sig_val_out (sig_val)
  );

  //////////////////////////////////////////////////////////////////////////
  // crystal ownership; an oscillator that is on keeps its pins even
  // in backup, since it runs from the backup supply
  assign low_on   = LOW_SPEED_CRYSTAL_OSC_ON_IN;
  assign high_on  = HIGH_SPEED_CRYSTAL_OSC_ON_IN;
  assign low_lost = (asy_s2_q[0] | asy_s2_q[1]) & ~low_on;

  // pins withdrawn from the general-purpose path
  assign osc_mask =
    ({{(PIN_COUNT-1){1'b0}}, low_on | low_lost}
       << PIN_LOW_HIGH_PIN_A) |
    ({{(PIN_COUNT-1){1'b0}}, low_on | low_lost}
       << PIN_LOW_HIGH_PIN_B) |
    ({{(PIN_COUNT-1){1'b0}}, high_on} << PIN_HIGH_A) |
    ({{(PIN_COUNT-1){1'b0}}, high_on} << PIN_HIGH_B);

  // per-pin choice between gpio and alternate function, bit by bit,
  // so C14/C15 stay independent while the crystal is off
  assign out_d  = ((AF_MODE_IN & af_out) | (~AF_MODE_IN & GPIO_DRV_IN))
                  & ~osc_mask;
  assign oe_d   = ((AF_MODE_IN & af_oe) | (~AF_MODE_IN & GPIO_OE_IN))
                  & ~osc_mask;
  assign gpio_d = pin_s2_q & ~osc_mask;
  assign analog_d = {2{low_lost}};

  // event sources: D0/D1 are bonded out only on the largest package
  assign event_ok_d = strap_done_q && (pkg_q == PKG_100);
  assign event_d = gpio_d &
    ~(({{(PIN_COUNT-1){1'b0}}, ~event_ok_d} << PIN_HIGH_A) |
      ({{(PIN_COUNT-1){1'b0}}, ~event_ok_d} << PIN_HIGH_B));

  //////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for pins, power status and strap
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pin_s1_q <= RST_PINS;
      pin_s2_q <= RST_PINS;
      asy_s1_q <= 4'h0;
      asy_s2_q <= 4'h0;
    end else begin
      pin_s1_q <= PIN_IN;
      pin_s2_q <= pin_s1_q;
      asy_s1_q <= {PACKAGE_STRAP_IN, BACKUP_ON_BATTERY_IN,
                   CORE_POWER_DOWN_IN};
      asy_s2_q <= asy_s1_q;
    end
  end

  // strap caught once, only after both synchroniser stages have
  // filled; earlier the second stage still holds its reset value
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      strap_wait_q <= 2'h0;
      pkg_q        <= PKG_36;
      strap_done_q <= 1'b0;
    end else begin
      strap_wait_q <= {strap_wait_q[0], 1'b1};
      if (strap_wait_q[1] && !strap_done_q) begin
        pkg_q        <= asy_s2_q[3:2];
        strap_done_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin-facing output registers
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PIN_OUT                 <= RST_PINS;
      PIN_OE_OUT              <= RST_PINS;
      GPIO_VAL_OUT            <= RST_PINS;
      EVENT_SRC_OUT           <= RST_PINS;
      LOW_OSC_ANALOG_OUT      <= 2'h0;
      LOW_OSC_PINS_OWNED_OUT  <= 1'b0;
      HIGH_OSC_PINS_OWNED_OUT <= 1'b0;
      EVENT_HIGH_PINS_OK_OUT  <= 1'b0;
    end else begin
      PIN_OUT                 <= out_d;
      PIN_OE_OUT              <= oe_d;
      GPIO_VAL_OUT            <= gpio_d;
      EVENT_SRC_OUT           <= event_d;
      LOW_OSC_ANALOG_OUT      <= analog_d;
      LOW_OSC_PINS_OWNED_OUT  <= low_on;
      HIGH_OSC_PINS_OWNED_OUT <= high_on;
      EVENT_HIGH_PINS_OK_OUT  <= event_ok_d;
    end
  end

  // peripheral-facing input registers
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SERIAL0_VAL_OUT     <= 2'h0;
      SERIAL1_VAL_OUT     <= 5'h00;
      SERIAL2_VAL_OUT     <= 5'h00;
      TWOWIRE0_VAL_OUT    <= 2'h0;
      SYNCSER0_VAL_OUT    <= 6'h00;
      SYNCSER2_VAL_OUT    <= 4'h0;
      TRIM_SYNC_INPUT_OUT <= 1'b0;
    end else begin
      SERIAL0_VAL_OUT     <= sig_val[SIG_SER0 +: 2];
      SERIAL1_VAL_OUT     <= sig_val[SIG_SER1 +: 5];
      SERIAL2_VAL_OUT     <= sig_val[SIG_SER2 +: 5];
      TWOWIRE0_VAL_OUT    <= sig_val[SIG_TW0 +: 2];
      SYNCSER0_VAL_OUT    <= sig_val[SIG_SS0 +: 6];
      SYNCSER2_VAL_OUT    <= sig_val[SIG_SS2 +: 4];
      TRIM_SYNC_INPUT_OUT <= sig_val[SIG_TRIM];
    end
  end

endmodule

// File: verif/pmx_pads.sv
// Purpose: pad model standing between the mux and the package pins
// Assumes: ext carries what the board drives on undriven pins
// Notes:   a pin the mux drives reads back its own drive level
module pmx_pads (
  input  wire logic [63:0] pin_out_in,
  input  wire logic [63:0] pin_oe_in,
  input  wire logic [63:0] ext_in,
  output logic      [63:0] pin_out
);
  // per pin resolution: mux drive beats the board
  assign pin_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_in);
endmodule

// File: verif/pmx_pin_remap_mux_asserts.sv
// Purpose: port-level checks for the pin remap mux
// Assumes: stimulus holds inputs for several edges
// Notes:   pin path allows two sync stages plus the output register
module pmx_asserts
  import pmx_pkg::*;
(
  input wire logic                 CLK_IN,
  input wire logic                 RST_B_IN,
  input wire logic [CFG1_W-1:0]    REMAP_CONFIG_REG_FIRST_IN,
  input wire logic [CFG2_W-1:0]    REMAP_CONFIG_REG_SECOND_IN,
  input wire logic                 LOW_SPEED_CRYSTAL_OSC_ON_IN,
  input wire logic                 HIGH_SPEED_CRYSTAL_OSC_ON_IN,
  input wire logic                 CORE_POWER_DOWN_IN,
  input wire logic                 BACKUP_ON_BATTERY_IN,
  input wire logic [1:0]           PACKAGE_STRAP_IN,
  input wire logic [PIN_COUNT-1:0] GPIO_DRV_IN,
  input wire logic [PIN_COUNT-1:0] GPIO_OE_IN,
  input wire logic [PIN_COUNT-1:0] AF_MODE_IN,
  input wire logic [PIN_COUNT-1:0] PIN_IN,
  input wire logic [1:0]           SERIAL0_DRV_IN,
  input wire logic [1:0]           SERIAL0_OE_IN,
  input wire logic [4:0]           SERIAL2_DRV_IN,
  input wire logic [4:0]           SERIAL2_OE_IN,
  input wire logic [PIN_COUNT-1:0] PIN_OUT,
  input wire logic [PIN_COUNT-1:0] PIN_OE_OUT,
  input wire logic [1:0]           LOW_OSC_ANALOG_OUT,
  input wire logic                 HIGH_OSC_PINS_OWNED_OUT,
  input wire logic                 EVENT_HIGH_PINS_OK_OUT,
  input wire logic [PIN_COUNT-1:0] EVENT_SRC_OUT,
  input wire logic                 TRIM_SYNC_INPUT_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  //////////////////////////////////////////////////////////////////////////
  // routed drive lands one edge after its cause
  a_ser0_base_tx: assert property (
    !REMAP_CONFIG_REG_FIRST_IN[0] && AF_MODE_IN[9] && SERIAL0_OE_IN[0]
    |=> PIN_OE_OUT[9] && PIN_OUT[9] == $past(SERIAL0_DRV_IN[0]))
    else $error("serial0 tx missing on base pin");
  a_ser0_alt_tx: assert property (
    REMAP_CONFIG_REG_FIRST_IN[0] && AF_MODE_IN[22] && SERIAL0_OE_IN[0]
    |=> PIN_OE_OUT[22] && PIN_OUT[22] == $past(SERIAL0_DRV_IN[0]))
    else $error("serial0 tx missing on alternate pin");
  // reserved code must fall back to the base mapping
  a_ser2_rsvd_code: assert property (
    REMAP_CONFIG_REG_FIRST_IN[3:2] == 2'h2 && AF_MODE_IN[26]
    && SERIAL2_OE_IN[0]
    |=> PIN_OE_OUT[26] && PIN_OUT[26] == $past(SERIAL2_DRV_IN[0]))
    else $error("serial2 reserved code moved tx");
  // sync input needs three edges of a steady pin
  a_trim_dflt_pin: assert property (
    (REMAP_CONFIG_REG_SECOND_IN != 2'h1 && PIN_IN[8])[*4]
    |-> TRIM_SYNC_INPUT_OUT)
    else $error("trim sync not taken from base pin");
  a_trim_alt_pin: assert property (
    (REMAP_CONFIG_REG_SECOND_IN == 2'h1 && PIN_IN[63])[*4]
    |-> TRIM_SYNC_INPUT_OUT)
    else $error("trim sync not taken from alternate pin");
  //////////////////////////////////////////////////////////////////////////
  // crystal ownership blocks every drive on its pins
  a_low_osc_mask: assert property (
    LOW_SPEED_CRYSTAL_OSC_ON_IN[*2] |-> PIN_OE_OUT[47:46] == 2'h0)
    else $error("low crystal pins still driven");
  a_high_osc_mask: assert property (
    HIGH_SPEED_CRYSTAL_OSC_ON_IN[*2]
    |-> PIN_OE_OUT[49:48] == 2'h0 && HIGH_OSC_PINS_OWNED_OUT)
    else $error("high crystal pins still driven");
  a_analog_force: assert property (
    ((CORE_POWER_DOWN_IN || BACKUP_ON_BATTERY_IN)
     && !LOW_SPEED_CRYSTAL_OSC_ON_IN)[*4]
    |-> LOW_OSC_ANALOG_OUT == 2'h3 && PIN_OE_OUT[47:46] == 2'h0)
    else $error("low crystal pins not forced analog");
  a_low_gpio_free: assert property (
    (!LOW_SPEED_CRYSTAL_OSC_ON_IN && !CORE_POWER_DOWN_IN
     && !BACKUP_ON_BATTERY_IN)[*4] ##0 (!AF_MODE_IN[46] && GPIO_OE_IN[46])
    |=> PIN_OE_OUT[46] && PIN_OUT[46] == $past(GPIO_DRV_IN[46]))
    else $error("low crystal pin not usable as gpio");
  // strap is captured a few edges after reset
  a_event_gate: assert property (
    (PACKAGE_STRAP_IN != 2'h3)[*5]
    |-> !EVENT_HIGH_PINS_OK_OUT && EVENT_SRC_OUT[49:48] == 2'h0)
    else $error("high crystal pins feed events on small package");
  c_ser2_rsvd: cover property (REMAP_CONFIG_REG_FIRST_IN[3:2] == 2'h2);
  c_analog: cover property (LOW_OSC_ANALOG_OUT == 2'h3);
  c_event_ok: cover property (EVENT_HIGH_PINS_OK_OUT);
endmodule

// File: verif/pmx_pin_remap_mux_bench.sv
// Purpose: self-checking bench for the pin remap mux
// Assumes: inputs change on the falling edge
// Notes:   waits of four edges cover both output latencies
module pmx_pin_remap_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, lo, hi, pd, bat, trv, lown, hown, eok;
  logic [6:0]  c1;
  logic [1:0]  c2, st, s0d, s0e, twd, twe, s0v, twv, lan;
  logic [4:0]  s1d, s1e, s2d, s2e, s1v, s2v;
  logic [5:0]  a0d, a0e, a0v;
  logic [3:0]  a2d, a2e, a2v;
  logic [63:0] gd, ge, af, ext, pin, po, poe, gv, es;
  int          n_fail, checks;
  pmx_pads i_pads (.pin_out_in(po), .pin_oe_in(poe), .ext_in(ext),
    .pin_out(pin));
  pmx_pin_remap_mux i_dut (.CLK_IN(clk), .RST_B_IN(rst_b),
    .REMAP_CONFIG_REG_FIRST_IN(c1), .REMAP_CONFIG_REG_SECOND_IN(c2),
    .LOW_SPEED_CRYSTAL_OSC_ON_IN(lo), .HIGH_SPEED_CRYSTAL_OSC_ON_IN(hi),
    .CORE_POWER_DOWN_IN(pd), .BACKUP_ON_BATTERY_IN(bat),
    .PACKAGE_STRAP_IN(st), .GPIO_DRV_IN(gd), .GPIO_OE_IN(ge),
    .AF_MODE_IN(af), .PIN_IN(pin), .SERIAL0_DRV_IN(s0d),
    .SERIAL0_OE_IN(s0e), .SERIAL1_DRV_IN(s1d), .SERIAL1_OE_IN(s1e),
    .SERIAL2_DRV_IN(s2d), .SERIAL2_OE_IN(s2e), .TWOWIRE0_DRV_IN(twd),
    .TWOWIRE0_OE_IN(twe), .SYNCSER0_DRV_IN(a0d), .SYNCSER0_OE_IN(a0e),
    .SYNCSER2_DRV_IN(a2d), .SYNCSER2_OE_IN(a2e), .PIN_OUT(po),
    .PIN_OE_OUT(poe), .GPIO_VAL_OUT(gv), .LOW_OSC_ANALOG_OUT(lan),
    .LOW_OSC_PINS_OWNED_OUT(lown), .HIGH_OSC_PINS_OWNED_OUT(hown),
    .EVENT_HIGH_PINS_OK_OUT(eok), .EVENT_SRC_OUT(es),
    .SERIAL0_VAL_OUT(s0v), .SERIAL1_VAL_OUT(s1v), .SERIAL2_VAL_OUT(s2v),
    .TWOWIRE0_VAL_OUT(twv), .SYNCSER0_VAL_OUT(a0v),
    .SYNCSER2_VAL_OUT(a2v), .TRIM_SYNC_INPUT_OUT(trv));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic wt;
    repeat (4) @(negedge clk);
  endtask
  // a driven slot must own its pin with the slot's level
  task automatic drv(input int p, input logic v);
    wt;
    chk(poe[p], 1'b1);
    chk(po[p], v);
  endtask
  task automatic rst;
    rst_b = 1'b0;
    repeat (8) @(negedge clk);
    chk(poe, 64'h0);
    rst_b = 1'b1;
  endtask
  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // both selects, drive then readback, old pin released
  task automatic t_ser;
    for (int s = 0; s < 2; s++) begin
      c1 = 7'(s * 3); s0e = 2'h1; s1e = 5'h04; ext = '0;
      ext[s ? 23 : 10] = 1'b1; ext[s ? 54 : 3] = 1'b1;
      drv(s ? 22 : 9, 1'b1);
      drv(s ? 53 : 2, 1'b1);
      chk({s1v[3], s0v[1]}, 2'h3);
      chk({poe[s ? 2 : 53], poe[s ? 9 : 22]}, 2'h0);
      s0d = 2'h0; drv(s ? 22 : 9, 1'b0);
      s0d = 2'h3; s0e = 2'h0; s1e = 5'h0;
    end
  endtask
  // every serial2 code, reserved one included
  task automatic t_ser2;
    int tx[4] = '{26, 42, 26, 56};
    int ct[4] = '{29, 29, 29, 59};
    s2e = 5'h09;
    for (int s = 0; s < 4; s++) begin
      c1 = 7'(s << 2); ext = '0; ext[tx[s] + 1] = 1'b1;
      drv(tx[s], 1'b1);
      drv(ct[s], 1'b1);
      chk(s2v[1], 1'b1);
    end
    s2e = 5'h0;
  endtask
  // two-wire and both synchronous ports, low then high select
  task automatic t_tw_ss;
    for (int s = 0; s < 2; s++) begin
      c1 = 7'(s * 7'h70); ext = '0; twd = 2'h0; twe = 2'h1;
      a0e = 6'h08; a2e = 4'h2;
      ext[s ? 25 : 23] = 1'b1; ext[s ? 20 : 6] = 1'b1;
      ext[s ? 43 : 20] = 1'b1;
      drv(s ? 24 : 22, 1'b0);
      drv(s ? 21 : 7, 1'b1);
      drv(s ? 42 : 19, 1'b1);
      chk({a2v[2], a0v[2], twv[1]}, 3'h7);
    end
    twe = 2'h0; a0e = 6'h0; a2e = 4'h0;
  endtask
  // trim select lives in the second word, first word ignored
  task automatic t_trim;
    c1 = 7'h7f;
    for (int s = 0; s < 4; s++) begin
      c2 = 2'(s); ext = '0; ext[s == 1 ? 63 : 8] = 1'b1;
      wt; chk(trv, 1'b1);
    end
    c2 = 2'h0; c1 = 7'h0;
  endtask
  // crystal pins as gpio, owned, and forced analog
  task automatic t_xtal;
    // C15 alone in alternate mode with no slot on it: C14 stays gpio
    af = '0; af[47] = 1'b1; ge = '1; gd = '1; gd[46] = 1'b0;
    wt; chk({poe[49:46], po[47:46], gv[47:46]}, 8'hd0);
    lo = 1'b1; wt; chk({lown, poe[47:46], gv[47:46]}, 5'h10);
    lo = 1'b0; pd = 1'b1; wt; chk({lan, poe[47:46]}, 4'hc);
    pd = 1'b0; bat = 1'b1; wt; chk(lan, 2'h3);
    lo = 1'b1; wt; chk(lan, 2'h0);
    lo = 1'b0; bat = 1'b0; hi = 1'b1;
    wt; chk({hown, poe[49:48]}, 3'h4);
    hi = 1'b0; ge = '0;
  endtask
  // each package strap after its own reset
  task automatic t_event;
    for (int s = 0; s < 4; s++) begin
      st = 2'(s); rst; ext = '0; ext[49:48] = 2'h3;
      wt; chk({eok, es[49:48], gv[49:48]}, s == 3 ? 5'h1f : 5'h03);
    end
    af = '1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #1ms;
    n_fail++;
    stop_test;
  end
  initial begin
    n_fail = 0; checks = 0; rst_b = 1'b0; c1 = '0; c2 = '0; st = 2'h3;
    {lo, hi, pd, bat} = 4'h0; gd = '0; ge = '0; af = '1; ext = '0;
    s0d = 2'h3; s0e = '0; s1d = '1; s1e = '0; s2d = '1; s2e = '0;
    twd = '0; twe = '0; a0d = '1; a0e = '0; a2d = '1; a2e = '0;
    @(negedge clk);
    rst;
    t_ser;
    t_ser2;
    t_tw_ss;
    t_trim;
    t_xtal;
    t_event;
    stop_test;
  end
endmodule

bind pmx_pin_remap_mux pmx_asserts i_chk (.*);
